// ---- design/msc_params.svh ----
// offsets, field positions, reset values and timing counts of the misc pin block
// assumes a 250 MHz pclk and a 32-bit APB word per register
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
`define MSC_OFS_CTRL      12'h000
`define MSC_OFS_AUX       12'h004
`define MSC_OFS_GAME      12'h008
`define MSC_OFS_FSTAT     12'h00C
`define MSC_CTRL_W        14
`define MSC_CTRL_RST      14'h0000
`define MSC_AUX_BASE_LSB  0
`define MSC_AUX_SIZE_LSB  16
`define MSC_AUX_RST       18'h00000
`define MSC_GAME_EN_BIT   16
`define MSC_GAME_RST      17'h00000
`define MSC_FST_SECOND_DRIVE_PRESENT_IN_BIT  7
`define MSC_FST_PWR_BIT   0
`define MSC_CLK_MHZ       250
`define MSC_IRQB_PULSE_NS 100
`define MSC_IRQB_PULSE_CYC ((`MSC_IRQB_PULSE_NS * `MSC_CLK_MHZ + 999) / 1000)
`endif

// ---- design/msc_pkg.sv ----
// types shared by the misc pin block
// constants live in msc_params.svh
package msc_pkg;
    typedef enum logic [1:0] {MSC_LPT_STD, MSC_LPT_BIDIR, MSC_LPT_EPP, MSC_LPT_ECP} msc_lpt_e;
    typedef enum logic [1:0] {MSC_UPM_OFF, MSC_UPM_FULL, MSC_UPM_AUTO, MSC_UPM_LOW} msc_upm_e;
    typedef enum logic {MSC_IB_IDLE, MSC_IB_PULSE} msc_ib_e;
    // control register layout, msb first
    typedef struct packed {
        msc_upm_e   uart1_pm;
        msc_upm_e   uart0_pm;
        logic       fdd_od;
        logic       fdd_on_lpt;
        msc_lpt_e   lpt_mode;
        logic       ext_en;
        logic [2:0] ext_sel;
        logic       irqb_en;
        logic       irqb_ext;
    } msc_ctrl_s;
    // decoded pin outputs: value and active-low enable
    typedef struct packed {
        logic out;
        logic oe_n;
    } msc_pin_s;
endpackage

// ---- design/msc_top.sv ----
// misc pin logic: address decodes, interrupt steering, supply gating, driver modes
// assumes APB on pclk; pin inputs are asynchronous and are synchronised here
`timescale 1ns/100ps
`include "msc_params.svh"

module msc_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    // two-flop synchroniser, meta is read only by q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

module msc_top
    import msc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] isa_addr,
    input  wire logic        isa_aen,
    input  wire logic        supply_valid_in,
    input  wire logic        second_drive_present_in,
    input  wire logic        external_interrupt_in,
    input  wire logic        ring_indicator_n,
    input  wire logic        device_irq,
    input  wire logic [1:0]  uart_irq,
    input  wire logic [3:0]  lpt_ctl_val,
    input  wire logic [3:0]  fdd_val,
    output logic             aux_block_decode_n,
    output logic             aux_block_decode_oe_n,
    output logic             game_port_select_n,
    output logic             game_port_select_oe_n,
    output logic             irq_b,
    output logic             irq_b_oe_n,
    output logic [7:0]       irq_output_lines,
    output logic [7:0]       irq_output_lines_oe_n,
    output logic             ring_indicator_out_n,
    output logic [1:0]       uart_irq_out,
    output logic [3:0]       lpt_ctl_out,
    output logic [3:0]       lpt_ctl_oe_n,
    output logic [3:0]       fdd_out,
    output logic [3:0]       fdd_oe_n
);
    localparam int PULSE_CYC = `MSC_IRQB_PULSE_CYC;
    localparam int PULSE_LAST = PULSE_CYC - 1;

    msc_ctrl_s   ctrl;
    logic [17:0] aux_cfg;
    logic [16:0] game_cfg;
    logic [20:0] raw_pins;
    logic [20:0] sync_pins;
    logic [15:0] s_addr;
    logic        s_aen;
    logic        s_pwr;
    logic        s_second_drive_present_in;
    logic        s_ext;
    logic        s_ri_n;
    logic        acc_wr;
    logic        setup;
    logic        mapped;
    logic        aux_hit;
    logic        game_hit;
    logic        enh_mode;
    logic        irqb_src;
    logic        irqb_src_q;
    msc_ib_e     ib_state;
    logic [7:0]  ib_cnt;
    logic [31:0] next_rdata;

    assign raw_pins = {isa_addr, isa_aen, supply_valid_in, second_drive_present_in,
                       external_interrupt_in, ring_indicator_n};
    msc_sync #(.W(21)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw_pins),
        .q       (sync_pins)
    );
    // inputs other than supply valid are parked while it is low
    assign s_pwr  = sync_pins[3];
    assign s_addr = s_pwr ? sync_pins[20:5] : 16'h0000;
    assign s_aen  = s_pwr ? sync_pins[4] : 1'b1;
    assign s_second_drive_present_in = s_pwr ? sync_pins[2] : 1'b1;
    assign s_ext  = s_pwr & sync_pins[1];
    assign s_ri_n = s_pwr ? sync_pins[0] : 1'b1;

    // apb decode; a write lands only at the access edge and only with supply valid,
    // so a supply drop between setup and access cannot slip a write through
    assign setup  = psel & ~penable;
    assign acc_wr = psel & penable & pready & pwrite & ~pslverr & s_pwr;
    assign mapped = (paddr == `MSC_OFS_CTRL) | (paddr == `MSC_OFS_AUX) |
                    (paddr == `MSC_OFS_GAME) | (paddr == `MSC_OFS_FSTAT);

    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            `MSC_OFS_CTRL:  next_rdata[`MSC_CTRL_W-1:0] = ctrl;
            `MSC_OFS_AUX:   next_rdata[17:0] = aux_cfg;
            `MSC_OFS_GAME:  next_rdata[16:0] = game_cfg;
            `MSC_OFS_FSTAT: begin
                next_rdata[`MSC_FST_SECOND_DRIVE_PRESENT_IN_BIT] = s_second_drive_present_in;
                next_rdata[`MSC_FST_PWR_BIT]  = s_pwr;
            end
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    // no wait state: answer prepared in setup, completed in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & (~mapped | (pwrite & ~s_pwr));
            prdata  <= (setup & ~pwrite & mapped) ? next_rdata : 32'h0000_0000;
        end
    end

    // configuration registers; writes refused while supply is invalid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= msc_ctrl_s'(`MSC_CTRL_RST);
            aux_cfg  <= `MSC_AUX_RST;
            game_cfg <= `MSC_GAME_RST;
        end else if (acc_wr) begin
            if (paddr == `MSC_OFS_CTRL)
                ctrl <= msc_ctrl_s'(pwdata[`MSC_CTRL_W-1:0]);
            if (paddr == `MSC_OFS_AUX)
                aux_cfg <= pwdata[17:0];
            if (paddr == `MSC_OFS_GAME)
                game_cfg <= pwdata[16:0];
        end
    end

    // address block and game port matches
    always_comb begin
        unique case (aux_cfg[`MSC_AUX_SIZE_LSB +: 2])
            2'h1: aux_hit = (s_addr == aux_cfg[15:0]);
            2'h2: aux_hit = (s_addr[15:3] == aux_cfg[15:3]);
            2'h3: aux_hit = (s_addr[15:4] == aux_cfg[15:4]);
            default: aux_hit = 1'b0;
        endcase
    end
    assign game_hit = game_cfg[`MSC_GAME_EN_BIT] & ~s_aen & (s_addr == game_cfg[15:0]);

    // decode pins: aux is open-drain, game select is push-pull
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_block_decode_n    <= 1'b1;
            aux_block_decode_oe_n <= 1'b1;
            game_port_select_n    <= 1'b1;
            game_port_select_oe_n <= 1'b1;
        end else begin
            aux_block_decode_n    <= ~aux_hit;
            aux_block_decode_oe_n <= ~(aux_hit & s_pwr);
            game_port_select_n    <= ~game_hit;
            game_port_select_oe_n <= ~s_pwr;
        end
    end

    // line B: source select and sharing pulse
    assign enh_mode = (ctrl.lpt_mode == MSC_LPT_EPP) | (ctrl.lpt_mode == MSC_LPT_ECP);
    assign irqb_src = ctrl.irqb_en & (ctrl.irqb_ext ? s_ext : (s_pwr & device_irq));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqb_src_q <= 1'b0;
            ib_state   <= MSC_IB_IDLE;
            ib_cnt     <= 8'h00;
        end else begin
            irqb_src_q <= irqb_src;
            unique case (ib_state)
                MSC_IB_IDLE: begin
                    if (enh_mode & irqb_src & ~irqb_src_q) begin
                        ib_state <= MSC_IB_PULSE;
                        ib_cnt   <= 8'(PULSE_CYC - 1);
                    end
                end
                MSC_IB_PULSE: begin
                    if (ib_cnt == 8'h00)
                        ib_state <= MSC_IB_IDLE;
                    else
                        ib_cnt <= ib_cnt - 8'h01;
                end
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_b      <= 1'b0;
            irq_b_oe_n <= 1'b1;
        end else if (enh_mode) begin
            irq_b      <= 1'b0;
            irq_b_oe_n <= ~(s_pwr & (ib_state == MSC_IB_PULSE));
        end else begin
            irq_b      <= irqb_src;
            irq_b_oe_n <= ~(s_pwr & ctrl.irqb_en);
        end
    end

    // external interrupt steering onto one of eight lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_output_lines      <= 8'h00;
            irq_output_lines_oe_n <= 8'hFF;
        end else begin
            for (int i = 0; i < 8; i++) begin
                irq_output_lines[i]      <= s_ext;
                irq_output_lines_oe_n[i] <= ~(s_pwr & ctrl.ext_en & (ctrl.ext_sel == 3'(i)));
            end
        end
    end

    // ring indicator and uart interrupts gated by supply and port power
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_indicator_out_n <= 1'b1;
            uart_irq_out         <= 2'h0;
        end else begin
            ring_indicator_out_n <= s_ri_n | ~((ctrl.uart0_pm == MSC_UPM_FULL) |
                                    (ctrl.uart0_pm == MSC_UPM_AUTO));
            uart_irq_out[0] <= s_pwr & uart_irq[0] & ((ctrl.uart0_pm == MSC_UPM_FULL) |
                               (ctrl.uart0_pm == MSC_UPM_AUTO));
            uart_irq_out[1] <= s_pwr & uart_irq[1] & ((ctrl.uart1_pm == MSC_UPM_FULL) |
                               (ctrl.uart1_pm == MSC_UPM_AUTO));
        end
    end

    // parallel control pins: push-pull in enhanced modes unless floppy signals are routed onto them, else open-drain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lpt_ctl_out  <= 4'h0;
            lpt_ctl_oe_n <= 4'hF;
            fdd_out      <= 4'h0;
            fdd_oe_n     <= 4'hF;
        end else if (!s_pwr) begin
            lpt_ctl_oe_n <= 4'hF;
            fdd_oe_n     <= 4'hF;
        end else if (ctrl.fdd_on_lpt) begin
            lpt_ctl_out  <= 4'h0;
            lpt_ctl_oe_n <= fdd_val;
            fdd_oe_n     <= 4'hF;
        end else begin
            lpt_ctl_out  <= enh_mode ? lpt_ctl_val : 4'h0;
            lpt_ctl_oe_n <= enh_mode ? 4'h0 : lpt_ctl_val;
            fdd_out      <= ctrl.fdd_od ? 4'h0 : fdd_val;
            fdd_oe_n     <= ctrl.fdd_od ? fdd_val : 4'h0;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_second_drive_present_in_readback: assert property (
        setup & ~pwrite & (paddr == `MSC_OFS_FSTAT) |=> prdata[`MSC_FST_SECOND_DRIVE_PRESENT_IN_BIT] == $past(s_second_drive_present_in))
        else $error("drive-two status not reported");
    chk_aux_decode: assert property (
        aux_hit & s_pwr |=> !aux_block_decode_n && !aux_block_decode_oe_n)
        else $error("aux decode not asserted");
    chk_irqb_source: assert property (
        !enh_mode & ctrl.irqb_en & s_pwr & $stable(ctrl) |=> irq_b == $past(irqb_src) && !irq_b_oe_n)
        else $error("line B level wrong");
    chk_irqb_pulse_len: assert property (
        $rose(ib_state == MSC_IB_PULSE) |->
            ##PULSE_LAST (ib_state == MSC_IB_PULSE) ##1 (ib_state == MSC_IB_IDLE))
        else $error("line B pulse length wrong");
    chk_supply_release: assert property (
        !s_pwr |=> game_port_select_oe_n && aux_block_decode_oe_n && (irq_output_lines_oe_n == 8'hFF))
        else $error("outputs driven without supply");
    chk_regs_hold: assert property (
        !s_pwr |=> $stable(ctrl) && $stable(aux_cfg) && $stable(game_cfg))
        else $error("registers changed without supply");
    chk_game_select: assert property (
        game_hit |=> !game_port_select_n)
        else $error("game select missing");
    chk_irq_steer: assert property (
        s_pwr & ctrl.ext_en & $stable(ctrl) |=> $countones(~irq_output_lines_oe_n) == 1)
        else $error("steering not one-hot");
    chk_uart_gate: assert property (
        ctrl.uart0_pm == MSC_UPM_OFF |=> !uart_irq_out[0] || $past(ctrl.uart0_pm) != MSC_UPM_OFF)
        else $error("uart interrupt passed while off");
    chk_fdd_on_lpt_od: assert property (
        s_pwr & ctrl.fdd_on_lpt |=> lpt_ctl_out == 4'h0)
        else $error("floppy pins on parallel port driven high");
    chk_enh_pushpull: assert property (
        s_pwr & enh_mode & !ctrl.fdd_on_lpt |=> lpt_ctl_oe_n == 4'h0)
        else $error("enhanced mode controls not push-pull");
    // further checks on bus writes, line B release and serial gating
    chk_ctrl_write: assert property (
        acc_wr & (paddr == `MSC_OFS_CTRL) |=>
            ctrl == msc_ctrl_s'($past(pwdata[`MSC_CTRL_W-1:0])))
        else $error("control write did not land");
    chk_apb_answer: assert property (
        setup |=> pready ##1 !pready)
        else $error("bus answer not one cycle");
    chk_irqb_release: assert property (
        enh_mode & (ib_state == MSC_IB_IDLE) |=> irq_b_oe_n)
        else $error("line B held while idle");
    chk_serial_supply: assert property (
        !s_pwr |=> ring_indicator_out_n && (uart_irq_out == 2'h0))
        else $error("serial signals passed without supply");
    cov_irqb_pulse: cover property ($rose(ib_state == MSC_IB_PULSE));
    cov_game_hit:   cover property (game_hit ##1 !game_port_select_n);
    cov_apb_write:  cover property (acc_wr);
    cov_supply_low: cover property ($fell(s_pwr));
endmodule

// ---- bench/msc_pins_model.sv ----
// pin-side partner: floppy cable presence and an external interrupt source
// assumes the bench sets drive_attached and irq_req on pclk edges
`timescale 1ns/100ps

module msc_pins_model (
    input  wire logic pclk,
    input  wire logic drive_attached,
    input  wire logic irq_req,
    output logic      second_drive_present_in,
    output logic      external_interrupt_in,
    output logic      reference_clock_in
);
    // pull-up on the presence line, pulled low by a fitted second drive
    assign second_drive_present_in = drive_attached ? 1'b0 : 1'b1;
    // external device raises its request level on a clock edge
    always_ff @(posedge pclk) begin
        external_interrupt_in <= irq_req;
    end
    // board oscillator on the reference clock pin, half of a 14.318 MHz period
    initial begin
        reference_clock_in = 1'b0;
        forever #34.9 reference_clock_in = ~reference_clock_in;
    end
endmodule

// ---- bench/msc_top_tb.sv ----
// self-checking bench for the misc pin block, driven over APB
// assumes msc_top and msc_pins_model are compiled first
`timescale 1ns/100ps
`include "msc_params.svh"

module msc_top_tb;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, isa_aen, supply_valid_in;
    logic [15:0] isa_addr;
    logic        drv_att, ext_req, sdp, ext_irq, ring_indicator_n, device_irq;
    logic [1:0]  uart_irq, uart_irq_out;
    logic [3:0]  lpt_ctl_val, fdd_val, lpt_ctl_out, lpt_ctl_oe_n, fdd_out, fdd_oe_n;
    logic        aux_n, aux_oe_n, game_n, game_oe_n, irq_b, irq_b_oe_n, ring_out_n;
    logic [7:0]  irq_lines, irq_lines_oe_n;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          lens [3] = '{1, 8, 16};
    int          cnt;

    msc_top msc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .isa_addr(isa_addr), .isa_aen(isa_aen),
        .supply_valid_in(supply_valid_in), .second_drive_present_in(sdp),
        .external_interrupt_in(ext_irq), .ring_indicator_n(ring_indicator_n),
        .device_irq(device_irq), .uart_irq(uart_irq), .lpt_ctl_val(lpt_ctl_val),
        .fdd_val(fdd_val), .aux_block_decode_n(aux_n), .aux_block_decode_oe_n(aux_oe_n),
        .game_port_select_n(game_n), .game_port_select_oe_n(game_oe_n), .irq_b(irq_b),
        .irq_b_oe_n(irq_b_oe_n), .irq_output_lines(irq_lines),
        .irq_output_lines_oe_n(irq_lines_oe_n), .ring_indicator_out_n(ring_out_n),
        .uart_irq_out(uart_irq_out), .lpt_ctl_out(lpt_ctl_out), .lpt_ctl_oe_n(lpt_ctl_oe_n),
        .fdd_out(fdd_out), .fdd_oe_n(fdd_oe_n));

    msc_pins_model msc_pins_model_inst (.pclk(pclk), .drive_attached(drv_att),
        .irq_req(ext_req), .second_drive_present_in(sdp), .external_interrupt_in(ext_irq),
        .reference_clock_in());

    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // counts and verdict, then stop
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // one APB transfer: setup, then access until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t bus timeout", $time);
            summarize();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, q, e);
        chk(32'(e), 32'(xe), "write status");
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(q, x, "read data");
        chk(32'(e), 32'(xe), "read status");
    endtask

    // let pin changes cross the synchroniser and output register
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask

    // main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; isa_addr = 16'h0000; isa_aen = 1'b1; supply_valid_in = 1'b1;
        drv_att = 1'b0; ext_req = 1'b0; ring_indicator_n = 1'b1; device_irq = 1'b0;
        uart_irq = 2'b00; lpt_ctl_val = 4'h0; fdd_val = 4'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`MSC_OFS_CTRL, 32'h0, 1'b0);
        rd(`MSC_OFS_AUX, 32'h0, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
        $display("test registers done");
        for (int s = 0; s < 2; s++) begin
            drv_att <= (s == 0);
            settle();
            rd(`MSC_OFS_FSTAT, (s == 0) ? 32'h01 : 32'h81, 1'b0);
        end
        $display("test drive status done");
        for (int s = 0; s < 3; s++) begin
            wr(`MSC_OFS_AUX, 32'h0310 | ((s + 1) << 16), 1'b0);
            isa_addr <= 16'h0310 + 16'(lens[s] - 1);
            settle();
            chk({aux_n, aux_oe_n}, 2'b00, "aux hit");
            isa_addr <= 16'h0310 + 16'(lens[s]);
            settle();
            chk(aux_oe_n, 1'b1, "aux miss");
        end
        $display("test aux decode done");
        wr(`MSC_OFS_GAME, 32'h10201, 1'b0);
        isa_addr <= 16'h0201;
        isa_aen <= 1'b0;
        settle();
        chk({game_n, game_oe_n}, 2'b00, "game hit");
        isa_aen <= 1'b1;
        settle();
        chk(game_n, 1'b1, "game needs aen");
        $display("test game select done");
        ext_req <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(`MSC_OFS_CTRL, 32'h20 | (i << 2), 1'b0);
            settle();
            chk(irq_lines_oe_n, {24'h0, ~(8'h01 << i)}, "irq line select");
            chk(irq_lines, 8'hFF, "irq line level");
        end
        $display("test irq steering done");
        device_irq <= 1'b1;
        ext_req <= 1'b0;
        wr(`MSC_OFS_CTRL, 32'h2, 1'b0);
        settle();
        chk({irq_b, irq_b_oe_n}, 2'b10, "line b device");
        wr(`MSC_OFS_CTRL, 32'h3, 1'b0);
        settle();
        chk({irq_b, irq_b_oe_n}, 2'b00, "line b external");
        lpt_ctl_val <= 4'hA;
        for (int m = 2; m < 4; m++) begin
            wr(`MSC_OFS_CTRL, 32'h3 | (m << 6), 1'b0);
            settle();
            chk({lpt_ctl_out, lpt_ctl_oe_n}, 8'hA0, "enhanced push-pull");
        end
        ext_req <= 1'b1;
        cnt = 0;
        while (irq_b_oe_n !== 1'b0 && cnt < 10) begin
            @(posedge pclk);
            cnt++;
        end
        cnt = 0;
        while (irq_b_oe_n === 1'b0 && irq_b === 1'b0 && cnt < 60) begin
            @(posedge pclk);
            cnt++;
        end
        chk(cnt, `MSC_IRQB_PULSE_CYC, "pulse width");
        settle();
        chk(irq_b_oe_n, 1'b1, "line released");
        $display("test line b done");
        fdd_val <= 4'h5;
        for (int od = 0; od < 2; od++) begin
            wr(`MSC_OFS_CTRL, 32'h100 | (od << 9), 1'b0);
            settle();
            chk({lpt_ctl_out, lpt_ctl_oe_n, fdd_oe_n}, 12'h05F, "floppy on lpt");
            wr(`MSC_OFS_CTRL, 32'h40 | (od << 9), 1'b0);
            settle();
            chk({lpt_ctl_out, lpt_ctl_oe_n, fdd_out, fdd_oe_n},
                od ? 16'h0A05 : 16'h0A50, "floppy driver type");
        end
        $display("test floppy pins done");
        wr(`MSC_OFS_CTRL, 32'h2420, 1'b0);
        uart_irq <= 2'b11;
        ring_indicator_n <= 1'b0;
        settle();
        chk({uart_irq_out, ring_out_n}, 3'b110, "uart irq pass");
        supply_valid_in <= 1'b0;
        settle();
        chk({irq_lines_oe_n, game_oe_n, aux_oe_n, irq_b_oe_n}, 11'h7FF, "outputs off");
        chk({lpt_ctl_oe_n, fdd_oe_n}, 8'hFF, "pins off");
        chk({uart_irq_out, ring_out_n}, 3'b001, "uart irq gated");
        wr(`MSC_OFS_CTRL, 32'h0, 1'b1);
        supply_valid_in <= 1'b1;
        settle();
        rd(`MSC_OFS_CTRL, 32'h2420, 1'b0);
        wr(`MSC_OFS_CTRL, 32'h3C00, 1'b0);
        settle();
        chk({uart_irq_out, ring_out_n}, 3'b001, "uart powered low");
        $display("test supply done");
        summarize();
    end
endmodule
